/* File: verilog/sdram_pkg.sv */
// Shared constants, command codes and burst arithmetic for the SDRAM link.
// Assumes both ends run on one clock and see the same pins in the same cycle.
package sdram_pkg;
	localparam int BANKS = 4;
	localparam int BA_W = 2;
	localparam int ROW_W = 13;
	localparam int COL_W = 9;
	localparam int ADDR_W = 13;
	localparam int DQ_W = 16;
	localparam int MEM_AW = BA_W + ROW_W + COL_W;
	localparam int AP_BIT = 10;

	// Mode register layout.
	localparam int BL_LSB = 0;
	localparam int BL_W = 3;
	localparam int BT_BIT = 3;
	localparam int CL_LSB = 4;
	localparam int CL_W = 3;
	localparam logic [BL_W-1:0] BL_PAGE = 3'h7;
	localparam logic [CL_W-1:0] CL_3 = 3'h3;
	localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0020;
	localparam logic [COL_W:0] PAGE_WORDS = 10'h200;

	// Internal refresh pacing while in self refresh, longest interval rounds down.
	localparam longint REFRESH_WINDOW_MS = 64;
	localparam longint CLK_HZ = 20000000;
	localparam int SREF_STEP_CYCLES =
		int'(REFRESH_WINDOW_MS * CLK_HZ / 1000 / (longint'(1) << ROW_W));
	localparam int SREF_CNT_W = $clog2(SREF_STEP_CYCLES + 1);

	// Command codes equal {ras_n, cas_n, we_n} with chip select low.
	typedef enum logic [2:0] {
		CMD_MODE = 3'h0,
		CMD_REFRESH = 3'h1,
		CMD_PRECHARGE = 3'h2,
		CMD_ROW_OPEN = 3'h3,
		CMD_WRITE = 3'h4,
		CMD_READ = 3'h5,
		CMD_STOP = 3'h6,
		CMD_NOP = 3'h7
	} cmd_t;

	// Controller register map.
	localparam int REG_AW = 8;
	localparam logic [REG_AW-1:0] REG_CMD = 8'h00;
	localparam logic [REG_AW-1:0] REG_CTRL = 8'h04;
	localparam logic [REG_AW-1:0] REG_STATUS = 8'h08;
	localparam logic [REG_AW-1:0] REG_WBUF = 8'h40;
	localparam logic [REG_AW-1:0] REG_RBUF = 8'h80;
	localparam logic [REG_AW-1:0] BUF_MASK = 8'h3c;
	localparam int IDX_LSB = 2;
	localparam int CF_CMD_LSB = 0;
	localparam int CF_BA_LSB = 3;
	localparam int CF_ADDR_LSB = 5;
	localparam int CTRL_CKE = 0;
	localparam int STS_BUSY = 0;
	localparam int STS_ERR = 1;
	localparam int STS_OPEN_LSB = 2;
	localparam int STS_CKE = 6;
	localparam int STS_RCNT_LSB = 8;
	localparam int RCNT_W = 8;

	function automatic cmd_t cmd_decode(input logic cs_n, input logic [2:0] rcw);
		return cs_n ? CMD_NOP : cmd_t'(rcw);
	endfunction

	function automatic logic [BL_W-1:0] mode_bl(input logic [ADDR_W-1:0] mode);
		return mode[BL_LSB +: BL_W];
	endfunction

	function automatic logic cl_is3(input logic [ADDR_W-1:0] mode);
		return mode[CL_LSB +: CL_W] == CL_3;
	endfunction

	function automatic logic [COL_W:0] burst_words(input logic [ADDR_W-1:0] mode);
		logic [BL_W-1:0] bl;
		bl = mode_bl(mode);
		if (bl == BL_PAGE) begin
			return PAGE_WORDS;
		end
		return (COL_W + 1)'(1) << bl[1:0];
	endfunction

	// Column of word cnt; the burst wraps inside its own aligned block.
	function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
			input logic [COL_W:0] cnt, input logic [ADDR_W-1:0] mode);
		logic [COL_W:0] words;
		logic [COL_W-1:0] mask;
		logic [COL_W-1:0] c;
		words = burst_words(mode);
		mask = COL_W'(words - (COL_W + 1)'(1));
		c = cnt[COL_W-1:0];
		if (mode[BT_BIT] && mode_bl(mode) != BL_PAGE) begin
			return (start & ~mask) | ((start ^ c) & mask);
		end
		return (start & ~mask) | ((start + c) & mask);
	endfunction

	function automatic logic burst_last(input logic [COL_W:0] cnt,
			input logic [ADDR_W-1:0] mode);
		return mode_bl(mode) != BL_PAGE && cnt == burst_words(mode) - (COL_W + 1)'(1);
	endfunction
endpackage

/* File: verilog/sdram_link.sv */
// Pin-level link between the SDRAM device and its controller.
// Assumes both ends share clk_sys; the data bus level is resolved here.
`timescale 1ns/100ps
interface sdram_link;
	import sdram_pkg::*;
	logic cs_n;
	logic ras_n;
	logic cas_n;
	logic we_n;
	logic cke;
	logic [BA_W-1:0] ba;
	logic [ADDR_W-1:0] addr;
	logic [DQ_W-1:0] ctl_dq;
	logic ctl_dq_oe_n;
	logic [DQ_W-1:0] dev_dq;
	logic dev_dq_oe_n;
	logic [DQ_W-1:0] dq;

	// An undriven bus reads as all ones, like a weak pull-up.
	assign dq = !ctl_dq_oe_n ? ctl_dq : (!dev_dq_oe_n ? dev_dq : '1);

	modport dev (
		input cs_n, ras_n, cas_n, we_n, cke, ba, addr, dq,
		output dev_dq, dev_dq_oe_n
	);
	modport ctl (
		output cs_n, ras_n, cas_n, we_n, cke, ba, addr, ctl_dq, ctl_dq_oe_n,
		input dq
	);
endinterface

/* File: verilog/sdram_device.sv */
// Four-bank x16 single-data-rate SDRAM device with bursts and refresh.
// Assumes a controller on the same clk_sys driving the pins from flip-flops.
`timescale 1ns/100ps
module sdram_device (
	input wire logic clk_sys, // system clock
	input wire logic srst, // synchronous reset, active high
	sdram_link.dev link, // command, address and data pins
	output logic power_down, // device is in power-down
	output logic self_refresh, // device is in self refresh
	output logic [sdram_pkg::ROW_W-1:0] refresh_row // next row due for refresh
);
	import sdram_pkg::*;

	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_PDOWN = 3'b010,
		ST_SREF = 3'b100
	} pstate_t;

	// The whole array; shrink the package widths for lighter simulation.
	logic [DQ_W-1:0] mem [0:(1 << MEM_AW)-1];

	pstate_t state_reg, state_next;
	logic cke_q_reg, cke_q_next;
	logic [ADDR_W-1:0] mode_reg, mode_next;
	logic [BANKS-1:0] open_reg, open_next;
	logic [ROW_W-1:0] row_reg [BANKS];
	logic [ROW_W-1:0] row_next [BANKS];
	logic act_reg, act_next;
	logic wr_reg, wr_next;
	logic ap_reg, ap_next;
	logic [BA_W-1:0] bank_reg, bank_next;
	logic [COL_W-1:0] start_reg, start_next;
	logic [COL_W:0] cnt_reg, cnt_next;
	logic [1:0] v_reg, v_next;
	logic [DQ_W-1:0] d0_reg, d0_next;
	logic [DQ_W-1:0] d1_reg, d1_next;
	logic [DQ_W-1:0] dq_out_reg, dq_out_next;
	logic oe_n_reg, oe_n_next;
	logic pd_reg, pd_next;
	logic sr_reg, sr_next;
	logic [ROW_W-1:0] ref_row_reg, ref_row_next;
	logic [SREF_CNT_W-1:0] sref_cnt_reg, sref_cnt_next;

	cmd_t cmd;
	logic issue;
	logic iwr;
	logic last;
	logic [BA_W-1:0] ibank;
	logic [COL_W-1:0] icol;
	logic [MEM_AW-1:0] iaddr;
	logic mem_we;

	assign cmd = cmd_decode(link.cs_n, {link.ras_n, link.cas_n, link.we_n});

	always_comb begin
		state_next = state_reg;
		cke_q_next = link.cke;
		mode_next = mode_reg;
		open_next = open_reg;
		row_next = row_reg;
		act_next = act_reg;
		wr_next = wr_reg;
		ap_next = ap_reg;
		bank_next = bank_reg;
		start_next = start_reg;
		cnt_next = cnt_reg;
		v_next = v_reg;
		d0_next = d0_reg;
		d1_next = d1_reg;
		dq_out_next = dq_out_reg;
		oe_n_next = oe_n_reg;
		ref_row_next = ref_row_reg;
		sref_cnt_next = sref_cnt_reg;
		issue = 1'b0;
		iwr = 1'b0;
		last = 1'b0;
		ibank = bank_reg;
		icol = start_reg;
		mem_we = 1'b0;
		unique case (state_reg)
			ST_RUN: begin
				// A gate sampled low on the previous edge suspends this one.
				if (cke_q_reg) begin
					if (cmd == CMD_READ || cmd == CMD_WRITE) begin
						// A new access cuts off any burst still running.
						ibank = link.ba;
						icol = link.addr[COL_W-1:0];
						iwr = (cmd == CMD_WRITE);
						issue = 1'b1;
						bank_next = link.ba;
						start_next = icol;
						wr_next = iwr;
						ap_next = link.addr[AP_BIT];
						cnt_next = (COL_W + 1)'(1);
						last = burst_last('0, mode_reg);
						act_next = !last;
						if (last && link.addr[AP_BIT]) begin
							open_next[link.ba] = 1'b0;
						end
					end else if (cmd == CMD_STOP) begin
						act_next = 1'b0;
					end else if (act_reg) begin
						icol = burst_col(start_reg, cnt_reg, mode_reg);
						iwr = wr_reg;
						issue = 1'b1;
						cnt_next = cnt_reg + (COL_W + 1)'(1);
						last = burst_last(cnt_reg, mode_reg);
						if (last) begin
							act_next = 1'b0;
							if (ap_reg) begin
								open_next[bank_reg] = 1'b0;
							end
						end
					end
					// Data pipeline: stage 0 is fetched, the output picks by latency.
					v_next = {v_reg[0], issue && !iwr};
					d1_next = d0_reg;
					d0_next = mem[iaddr];
					if (cl_is3(mode_reg)) begin
						dq_out_next = d1_reg;
						oe_n_next = !v_reg[1];
					end else begin
						dq_out_next = d0_reg;
						oe_n_next = !v_reg[0];
					end
					mem_we = issue && iwr;
					unique case (cmd)
						CMD_MODE: mode_next = link.addr;
						CMD_ROW_OPEN: begin
							open_next[link.ba] = 1'b1;
							row_next[link.ba] = link.addr[ROW_W-1:0];
						end
						CMD_PRECHARGE: begin
							if (link.addr[AP_BIT]) begin
								open_next = '0;
							end else begin
								open_next[link.ba] = 1'b0;
							end
						end
						CMD_REFRESH: begin
							if (link.cke) begin
								ref_row_next = ref_row_reg + ROW_W'(1);
							end else if (open_reg == '0 && !act_reg) begin
								state_next = ST_SREF;
								sref_cnt_next = '0;
							end
						end
						default: begin
						end
					endcase
					if (!link.cke && cmd != CMD_REFRESH && open_reg == '0 && !act_reg) begin
						state_next = ST_PDOWN;
					end
				end
			end
			ST_PDOWN: begin
				if (link.cke) begin
					state_next = ST_RUN;
				end
			end
			ST_SREF: begin
				if (sref_cnt_reg == SREF_CNT_W'(SREF_STEP_CYCLES - 1)) begin
					sref_cnt_next = '0;
					ref_row_next = ref_row_reg + ROW_W'(1);
				end else begin
					sref_cnt_next = sref_cnt_reg + SREF_CNT_W'(1);
				end
				if (link.cke) begin
					state_next = ST_RUN;
				end
			end
		endcase
		iaddr = {ibank, row_reg[ibank], icol};
		pd_next = (state_next == ST_PDOWN);
		sr_next = (state_next == ST_SREF);
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= ST_RUN;
			cke_q_reg <= 1'b1;
			mode_reg <= MODE_RESET;
			open_reg <= '0;
			for (int i = 0; i < BANKS; i++) begin
				row_reg[i] <= '0;
			end
			act_reg <= 1'b0;
			wr_reg <= 1'b0;
			ap_reg <= 1'b0;
			bank_reg <= '0;
			start_reg <= '0;
			cnt_reg <= '0;
			v_reg <= '0;
			d0_reg <= '0;
			d1_reg <= '0;
			dq_out_reg <= '0;
			oe_n_reg <= 1'b1;
			pd_reg <= 1'b0;
			sr_reg <= 1'b0;
			ref_row_reg <= '0;
			sref_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			cke_q_reg <= cke_q_next;
			mode_reg <= mode_next;
			open_reg <= open_next;
			row_reg <= row_next;
			act_reg <= act_next;
			wr_reg <= wr_next;
			ap_reg <= ap_next;
			bank_reg <= bank_next;
			start_reg <= start_next;
			cnt_reg <= cnt_next;
			v_reg <= v_next;
			d0_reg <= d0_next;
			d1_reg <= d1_next;
			dq_out_reg <= dq_out_next;
			oe_n_reg <= oe_n_next;
			pd_reg <= pd_next;
			sr_reg <= sr_next;
			ref_row_reg <= ref_row_next;
			sref_cnt_reg <= sref_cnt_next;
		end
	end

	// Contents survive reset on purpose, as in a real part.
	always_ff @(posedge clk_sys) begin
		if (mem_we) begin
			mem[iaddr] <= link.dq;
		end
	end

	assign link.dev_dq = dq_out_reg;
	assign link.dev_dq_oe_n = oe_n_reg;
	assign power_down = pd_reg;
	assign self_refresh = sr_reg;
	assign refresh_row = ref_row_reg;
endmodule

/* File: verilog/sdram_ctrl.sv */
// SDRAM controller end: software registers in, command pins out.
// Assumes the device shares clk_sys; it mirrors the device burst state.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
module sdram_ctrl #(
	parameter int BUF_AW = 3 // log2 of the burst data buffer depth
) (
	input wire logic clk_sys, // system clock
	input wire logic srst, // synchronous reset, active high
	input wire logic [sdram_pkg::REG_AW-1:0] reg_addr, // register byte address
	input wire logic [31:0] reg_wdata, // register write data
	input wire logic reg_wr, // write strobe
	input wire logic reg_rd, // read strobe
	output logic [31:0] reg_rdata, // read data, cycle after reg_rd
	sdram_link.ctl link // command, address and data pins
);
	import sdram_pkg::*;

	localparam int DEPTH = 1 << BUF_AW;

	logic [DQ_W-1:0] wbuf [DEPTH];
	logic [DQ_W-1:0] rbuf [DEPTH];

	logic cs_n_reg, cs_n_next;
	logic [2:0] rcw_reg, rcw_next;
	logic [BA_W-1:0] ba_reg, ba_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic cke_reg, cke_next;
	logic cke_seen_reg, cke_seen_next;
	logic [DQ_W-1:0] dq_out_reg, dq_out_next;
	logic oe_n_reg, oe_n_next;
	logic [ADDR_W-1:0] mode_reg, mode_next;
	logic [BANKS-1:0] open_reg, open_next;
	logic act_reg, act_next;
	logic wr_reg, wr_next;
	logic ap_reg, ap_next;
	logic [BA_W-1:0] bank_reg, bank_next;
	logic [COL_W:0] cnt_reg, cnt_next;
	logic [1:0] v_reg, v_next;
	logic cap_reg, cap_next;
	logic [RCNT_W-1:0] rcnt_reg, rcnt_next;
	logic err_reg, err_next;
	logic [31:0] rdata_reg, rdata_next;

	cmd_t dcmd;
	cmd_t req;
	logic [BA_W-1:0] req_ba;
	logic refuse;
	logic wbuf_we;

	// What the device samples on this edge is what these pins hold now.
	assign dcmd = cmd_decode(cs_n_reg, rcw_reg);
	assign req = cmd_t'(reg_wdata[CF_CMD_LSB +: 3]);
	assign req_ba = reg_wdata[CF_BA_LSB +: BA_W];
	assign wbuf_we = reg_wr && (reg_addr & ~BUF_MASK) == REG_WBUF;

	always_comb begin
		cs_n_next = 1'b1;
		rcw_next = CMD_NOP;
		ba_next = ba_reg;
		addr_next = addr_reg;
		cke_next = cke_reg;
		cke_seen_next = cke_reg;
		dq_out_next = dq_out_reg;
		oe_n_next = oe_n_reg;
		mode_next = mode_reg;
		open_next = open_reg;
		act_next = act_reg;
		wr_next = wr_reg;
		ap_next = ap_reg;
		bank_next = bank_reg;
		cnt_next = cnt_reg;
		v_next = v_reg;
		cap_next = 1'b0;
		rcnt_next = rcnt_reg;
		err_next = err_reg;
		refuse = 1'b0;
		if (reg_wr && reg_addr == REG_CTRL) begin
			cke_next = reg_wdata[CTRL_CKE];
		end
		if (cap_reg) begin
			rcnt_next = rcnt_reg + RCNT_W'(1);
		end
		// Mirror of the device, frozen on edges the device also skips.
		if (cke_seen_reg) begin
			if (dcmd == CMD_READ || dcmd == CMD_WRITE) begin
				bank_next = ba_reg;
				wr_next = (dcmd == CMD_WRITE);
				ap_next = addr_reg[AP_BIT];
				cnt_next = (COL_W + 1)'(1);
				act_next = !burst_last('0, mode_reg);
				v_next = {v_reg[0], dcmd == CMD_READ};
				if (!act_next && addr_reg[AP_BIT]) begin
					open_next[ba_reg] = 1'b0;
				end
			end else if (dcmd == CMD_STOP) begin
				act_next = 1'b0;
				v_next = {v_reg[0], 1'b0};
			end else begin
				v_next = {v_reg[0], act_reg && !wr_reg};
				if (act_reg) begin
					cnt_next = cnt_reg + (COL_W + 1)'(1);
					if (burst_last(cnt_reg, mode_reg)) begin
						act_next = 1'b0;
						if (ap_reg) begin
							open_next[bank_reg] = 1'b0;
						end
					end
				end
			end
			cap_next = cl_is3(mode_reg) ? v_reg[1] : v_reg[0];
			unique case (dcmd)
				CMD_MODE: mode_next = addr_reg;
				CMD_ROW_OPEN: open_next[ba_reg] = 1'b1;
				CMD_PRECHARGE: begin
					if (addr_reg[AP_BIT]) begin
						open_next = '0;
					end else begin
						open_next[ba_reg] = 1'b0;
					end
				end
				default: begin
				end
			endcase
			dq_out_next = wbuf[cnt_next[BUF_AW-1:0]];
			oe_n_next = !(act_next && wr_next);
		end
		if (reg_wr && reg_addr == REG_CMD) begin
			if (!cke_reg || !cke_seen_reg) begin
				refuse = 1'b1;
			end else if ((req == CMD_READ || req == CMD_WRITE) && !open_next[req_ba]) begin
				refuse = 1'b1;
			end else if (req == CMD_ROW_OPEN && open_next[req_ba]) begin
				refuse = 1'b1;
			end else begin
				cs_n_next = 1'b0;
				rcw_next = req;
				ba_next = req_ba;
				addr_next = reg_wdata[CF_ADDR_LSB +: ADDR_W];
				if (req == CMD_WRITE) begin
					dq_out_next = wbuf[0];
					oe_n_next = 1'b0;
				end
				if (req == CMD_READ) begin
					rcnt_next = '0;
				end
				// A refresh with address bit ten set drops the gate with it.
				// The device can then enter self refresh, which a separate gate write could never reach.
				if (req == CMD_REFRESH && reg_wdata[CF_ADDR_LSB + AP_BIT]) begin
					cke_next = 1'b0;
				end
			end
		end
		if (reg_wr && reg_addr == REG_STATUS && reg_wdata[STS_ERR]) begin
			err_next = 1'b0;
		end
		if (refuse) begin
			err_next = 1'b1;
		end
		rdata_next = '0;
		if (reg_rd) begin
			if (reg_addr == REG_CTRL) begin
				rdata_next[CTRL_CKE] = cke_reg;
			end else if (reg_addr == REG_STATUS) begin
				rdata_next[STS_BUSY] = act_reg || v_reg != '0 || cap_reg;
				rdata_next[STS_ERR] = err_reg;
				rdata_next[STS_OPEN_LSB +: BANKS] = open_reg;
				rdata_next[STS_CKE] = cke_seen_reg;
				rdata_next[STS_RCNT_LSB +: RCNT_W] = rcnt_reg;
			end else if ((reg_addr & ~BUF_MASK) == REG_WBUF) begin
				rdata_next[DQ_W-1:0] = wbuf[reg_addr[IDX_LSB +: BUF_AW]];
			end else if ((reg_addr & ~BUF_MASK) == REG_RBUF) begin
				rdata_next[DQ_W-1:0] = rbuf[reg_addr[IDX_LSB +: BUF_AW]];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cs_n_reg <= 1'b1;
			rcw_reg <= CMD_NOP;
			ba_reg <= '0;
			addr_reg <= '0;
			cke_reg <= 1'b1;
			cke_seen_reg <= 1'b1;
			dq_out_reg <= '0;
			oe_n_reg <= 1'b1;
			mode_reg <= MODE_RESET;
			open_reg <= '0;
			act_reg <= 1'b0;
			wr_reg <= 1'b0;
			ap_reg <= 1'b0;
			bank_reg <= '0;
			cnt_reg <= '0;
			v_reg <= '0;
			cap_reg <= 1'b0;
			rcnt_reg <= '0;
			err_reg <= 1'b0;
			rdata_reg <= '0;
		end else begin
			cs_n_reg <= cs_n_next;
			rcw_reg <= rcw_next;
			ba_reg <= ba_next;
			addr_reg <= addr_next;
			cke_reg <= cke_next;
			cke_seen_reg <= cke_seen_next;
			dq_out_reg <= dq_out_next;
			oe_n_reg <= oe_n_next;
			mode_reg <= mode_next;
			open_reg <= open_next;
			act_reg <= act_next;
			wr_reg <= wr_next;
			ap_reg <= ap_next;
			bank_reg <= bank_next;
			cnt_reg <= cnt_next;
			v_reg <= v_next;
			cap_reg <= cap_next;
			rcnt_reg <= rcnt_next;
			err_reg <= err_next;
			rdata_reg <= rdata_next;
		end
	end

	// Buffers hold data only, so they need no reset.
	always_ff @(posedge clk_sys) begin
		if (wbuf_we) begin
			wbuf[reg_addr[IDX_LSB +: BUF_AW]] <= reg_wdata[DQ_W-1:0];
		end
		if (cap_reg) begin
			rbuf[rcnt_reg[BUF_AW-1:0]] <= link.dq;
		end
	end

	assign link.cs_n = cs_n_reg;
	assign link.ras_n = rcw_reg[2];
	assign link.cas_n = rcw_reg[1];
	assign link.we_n = rcw_reg[0];
	assign link.cke = cke_reg;
	assign link.ba = ba_reg;
	assign link.addr = addr_reg;
	assign link.ctl_dq = dq_out_reg;
	assign link.ctl_dq_oe_n = oe_n_reg;
	assign reg_rdata = rdata_reg;
endmodule

/* File: tb/sdram_burst_core_props.sv */
// Pin-level checks on the link between the SDRAM device and its controller.
// Assumes one clk_sys and a mode mirror rebuilt here from mode commands.
`timescale 1ns/100ps
module sdram_burst_core_props (
	input wire logic clk_sys, // system clock
	input wire logic srst, // synchronous reset
	input wire logic cs_n, // chip select, low active
	input wire logic ras_n, // row strobe, low active
	input wire logic cas_n, // column strobe, low active
	input wire logic we_n, // write enable, low active
	input wire logic cke, // clock gate
	input wire logic [sdram_pkg::ADDR_W-1:0] addr, // address pins
	input wire logic ctl_dq_oe_n, // controller drives data when low
	input wire logic [sdram_pkg::DQ_W-1:0] dev_dq, // device read data
	input wire logic dev_dq_oe_n, // device drives data when low
	input wire logic power_down, // device in power-down
	input wire logic [sdram_pkg::ROW_W-1:0] refresh_row // next refresh row
);
	import sdram_pkg::*;
	logic cke_q;
	logic [ADDR_W-1:0] mode_q;
	logic [2:0] rcw;
	logic live;
	logic cl2;
	logic [BL_W-1:0] bl;
	assign rcw = {ras_n, cas_n, we_n};
	// A command counts only when the gate was high one edge before.
	assign live = !cs_n && cke_q;
	assign cl2 = mode_q[CL_LSB +: CL_W] == 3'h2;
	assign bl = mode_q[BL_LSB +: BL_W];
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cke_q <= 1'b1;
			mode_q <= MODE_RESET;
		end else begin
			cke_q <= cke;
			if (live && rcw == CMD_MODE) begin
				mode_q <= addr;
			end
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	sequence word_pair_s; (!dev_dq_oe_n) [*2] ##1 dev_dq_oe_n; endsequence
	sequence word_quad_s; (!dev_dq_oe_n) [*4] ##1 dev_dq_oe_n; endsequence
	bus_exclusive_a: assert property (ctl_dq_oe_n || dev_dq_oe_n)
		else $error("Both ends drive the data bus.");
	write_drive_a: assert property (live && rcw == CMD_WRITE |-> !ctl_dq_oe_n)
		else $error("Write command without write data.");
	read_lat2_a: assert property (live && rcw == CMD_READ && cl2 |->
		##1 dev_dq_oe_n ##1 !dev_dq_oe_n) else $error("Latency two missed.");
	read_lat3_a: assert property (live && rcw == CMD_READ && !cl2 |->
		##1 dev_dq_oe_n [*2] ##1 !dev_dq_oe_n) else $error("Latency three missed.");
	burst_quad_a: assert property (live && rcw == CMD_READ && cl2 && bl == 3'h2 |->
		##2 word_quad_s) else $error("Four word burst wrong length.");
	burst_pair_a: assert property (live && rcw == CMD_READ && !cl2 && bl == 3'h1 |->
		##3 word_pair_s) else $error("Two word burst wrong length.");
	stop_drain_a: assert property (live && rcw == CMD_STOP && cl2 |->
		##2 dev_dq_oe_n) else $error("Data still out after burst stop.");
	refresh_step_a: assert property (live && rcw == CMD_REFRESH && cke |=>
		refresh_row == ROW_W'($past(refresh_row) + 1'b1)) else $error("Refresh row not stepped.");
	gate_freeze_a: assert property ($past(cke, 2) == 1'b0 |->
		$stable(dev_dq_oe_n) && $stable(dev_dq)) else $error("Output moved while gated.");
	pd_entry_a: assert property ($rose(power_down) |-> $past(cke) == 1'b0)
		else $error("Power-down without gate low.");
	pd_exit_a: assert property (power_down && cke |=> !power_down)
		else $error("Power-down not left with gate high.");
endmodule

/* File: tb/sdram_burst_core_tb_top.sv */
// Testbench joining controller and device; software drives the register port.
// Assumes the package geometry and a controller buffer of eight words.
`timescale 1ns/100ps
module sdram_burst_core_tb_top;
	import sdram_pkg::*;
	logic clk_sys;
	logic srst;
	logic [REG_AW-1:0] reg_addr;
	logic [31:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [31:0] reg_rdata;
	logic power_down;
	logic self_refresh;
	logic [ROW_W-1:0] refresh_row;
	int err_count;
	int n_checks;
	sdram_link i_sdram_link ();
	sdram_device i_sdram_device (.clk_sys(clk_sys), .srst(srst), .link(i_sdram_link),
		.power_down(power_down), .self_refresh(self_refresh), .refresh_row(refresh_row));
	sdram_ctrl #(.BUF_AW(3)) i_sdram_ctrl (.clk_sys(clk_sys), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .link(i_sdram_link));
	sdram_burst_core_props i_sdram_burst_core_props (.clk_sys(clk_sys), .srst(srst),
		.cs_n(i_sdram_link.cs_n), .ras_n(i_sdram_link.ras_n), .cas_n(i_sdram_link.cas_n),
		.we_n(i_sdram_link.we_n), .cke(i_sdram_link.cke), .addr(i_sdram_link.addr),
		.ctl_dq_oe_n(i_sdram_link.ctl_dq_oe_n), .dev_dq(i_sdram_link.dev_dq),
		.dev_dq_oe_n(i_sdram_link.dev_dq_oe_n), .power_down(power_down),
		.refresh_row(refresh_row));
	task automatic give_verdict();
		$display("Checks %0d, errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic reg_write(input logic [REG_AW-1:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [REG_AW-1:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask
	task automatic cmd(input cmd_t c, input logic [1:0] b, input logic [ADDR_W-1:0] a);
		reg_write(REG_CMD, {14'h0, a, b, c});
	endtask
	task automatic wait_idle();
		logic [31:0] s;
		for (int i = 0; i < 40; i++) begin
			reg_read(REG_STATUS, s);
			if (s[STS_BUSY] === 1'b0) begin
				break;
			end
		end
		check({31'h0, s[STS_BUSY]}, 32'h0, "busy");
	endtask
	task automatic t_fill();
		logic [31:0] s;
		check(32'(refresh_row), 32'h0, "refresh row at reset");
		reg_read(8'h0c, s);
		check(s, 32'h0, "unmapped read");
		for (int i = 0; i < 8; i++) begin
			reg_write(REG_WBUF + 8'(4 * i), {16'h0, 16'h00a0 + 16'(i)});
		end
		cmd(CMD_MODE, 2'h0, 13'h0023);
		cmd(CMD_ROW_OPEN, 2'h2, 13'h0005);
		cmd(CMD_WRITE, 2'h2, 13'h0000);
		wait_idle();
	endtask
	task automatic read_check(input logic [2:0] cl, input logic bt, input logic [2:0] bl,
			input logic [COL_W-1:0] col, input logic ap);
		logic [31:0] got;
		logic [COL_W-1:0] c;
		logic [COL_W-1:0] m;
		int n;
		n = 1 << bl;
		m = COL_W'(n - 1);
		cmd(CMD_MODE, 2'h0, {6'h0, cl, bt, bl});
		cmd(CMD_READ, 2'h2, {2'h0, ap, 1'b0, col});
		wait_idle();
		reg_read(REG_STATUS, got);
		check({24'h0, got[15:8]}, 32'(n), "words captured");
		check({28'h0, got[5:2]}, ap ? 32'h0 : 32'h4, "open banks");
		for (int k = 0; k < n; k++) begin
			c = bt ? ((col ^ COL_W'(k)) & m) : ((col + COL_W'(k)) & m);
			c = c | (col & ~m);
			reg_read(REG_RBUF + 8'(4 * k), got);
			check(got, {16'h0, 16'h00a0 + 16'(c)}, "burst word");
		end
	endtask
	task automatic t_stop();
		logic [31:0] s;
		cmd(CMD_MODE, 2'h0, 13'h0027);
		cmd(CMD_ROW_OPEN, 2'h2, 13'h0005);
		cmd(CMD_READ, 2'h2, 13'h0000);
		cmd(CMD_STOP, 2'h0, 13'h0000);
		wait_idle();
		reg_read(REG_STATUS, s);
		check({31'h0, s[15:8] inside {[1:3]}}, 32'h1, "stopped burst count");
		reg_read(REG_RBUF, s);
		check(s, 32'h0000_00a0, "page word");
	endtask
	task automatic t_power();
		logic [31:0] s;
		logic [ROW_W-1:0] r0;
		cmd(CMD_PRECHARGE, 2'h0, 13'h0400);
		cmd(CMD_READ, 2'h1, 13'h0000);
		reg_read(REG_STATUS, s);
		check({30'h0, s[STS_ERR], 1'b0}, 32'h2, "closed bank refused");
		reg_write(REG_STATUS, 32'h2);
		reg_read(REG_STATUS, s);
		check({26'h0, s[5:0]}, 32'h0, "error cleared");
		r0 = refresh_row;
		cmd(CMD_REFRESH, 2'h0, 13'h0000);
		repeat (2) @(posedge clk_sys);
		check(32'(refresh_row), 32'(ROW_W'(r0 + 1'b1)), "refresh step");
		r0 = refresh_row;
		reg_write(REG_CTRL, 32'h0);
		repeat (3) @(posedge clk_sys);
		check({31'h0, power_down}, 32'h1, "power-down entry");
		cmd(CMD_REFRESH, 2'h0, 13'h0000);
		check(32'(refresh_row), 32'(r0), "gated refresh");
		reg_write(REG_CTRL, 32'h1);
		repeat (3) @(posedge clk_sys);
		check({31'h0, power_down}, 32'h0, "power-down exit");
		reg_read(REG_CTRL, s);
		check(s, 32'h1, "gate control");
		cmd(CMD_REFRESH, 2'h0, 13'h0400);
		repeat (3) @(posedge clk_sys);
		check({31'h0, self_refresh}, 32'h1, "self refresh entry");
		r0 = refresh_row;
		repeat (200) @(posedge clk_sys);
		check(32'(refresh_row), 32'(ROW_W'(r0 + 1'b1)), "self refresh step");
		reg_write(REG_CTRL, 32'h1);
		repeat (3) @(posedge clk_sys);
		check({31'h0, self_refresh}, 32'h0, "self refresh exit");
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		srst = 1'b1;
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		err_count = 0;
		n_checks = 0;
		repeat (4) @(posedge clk_sys);
		srst <= 1'b0;
		t_fill();
		read_check(3'h2, 1'b0, 3'h2, 9'h001, 1'b0);
		read_check(3'h2, 1'b1, 3'h2, 9'h001, 1'b0);
		read_check(3'h3, 1'b0, 3'h1, 9'h003, 1'b0);
		read_check(3'h2, 1'b0, 3'h0, 9'h006, 1'b0);
		read_check(3'h3, 1'b1, 3'h3, 9'h005, 1'b1);
		t_stop();
		t_power();
		give_verdict();
	end
	// The whole sequence needs well under two thousand cycles.
	initial begin
		repeat (20000) @(posedge clk_sys);
		err_count++;
		$display("ERROR at %0t: timeout", $time);
		give_verdict();
	end
endmodule
